// File: rtl/aau_top.sv
/*
  Accumulator add and shift unit with an AXI4-Lite register slave.
  Software loads operands, then writes an instruction word to run it.
  Assumes one clock, synchronous active-low reset.
*/
// Notes on behaviour
// RL1: After a store, fetch is stale five instructions; a mode switch ends it.
// RL2: Memory-reference opcode sits in bits 3-6; octal 14 is input/output.
// RL3: Opcode octal 15 uses the index bit as opcode, not indexing.
// RL4: Long memory-reference adds an opcode extension in bits 13-14.
// RL5: Address-pointer instructions carry a generic word plus a 32-bit pointer.
// RL6: Bits 1-2 pick generic A, generic B, shift or skip.
// RL7: Shift field is the negated count; zero means 64 steps.
// RL8: Increment by one; max positive wraps to most negative with exception.
// RL9: Add two; the two top values load most negative or one above.
// RL10: Exception sets carry flag, else cleared; keys bit 8 raises fault.
// RL11: Enqueue at bottom; EQ when full else NE; carry and link kept.
// RL12: Carry flag added to accumulator; max positive with carry overflows.
// RL13: Add memory word into accumulator; link takes carry, codes follow result.
// RL14: Add overflow signals exception and loads the fixed bound values.
// RL15: Long add of a 32-bit operand with 32-bit bounds and exception.
// RL16: Link added into long register; max positive with link overflows.
// RL17: Long register offset added to chosen field address; codes unchanged.
// RL18: Left logical shift brings zeros in; carry gets last bit out.
// RL19: Left rotate moves bit 1 into bit 16; carry gets last bit.
// RL20: The long register is 32 bits wide.
// RL21: Condition codes record whether the signed result is zero or negative.
`timescale 1ns/1ps
module aau_top #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic int_fault,
  output logic enq_valid,
  output logic [15:0] enq_data,
  output logic [31:0] enq_ap,
  output logic fetch_stale
);
  import aau_pkg::*;
  // Elaboration check: the register map needs at least six address bits.
  if (ADDR_W < 6) begin : g_addr_chk
    $error("ADDR_W too small for the register map.");
  end
  // ==========================================
  // State and architectural registers.
  aau_state_t state_q;
  aau_dec_t dec;
  logic [15:0] instr_q, acc_q;
  logic [31:0] operand_q, long_q, far_q [2];
  logic carry_q, link_q, cc_lt_q, cc_eq_q, fault_en_q, qfull_q;
  logic fault_seen_q, exc_q, unsup_q;
  logic [2:0] fence_q;
  logic [6:0] steps_q;
  logic aw_have_q, w_have_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  aau_decode u_dec (.ins(instr_q), .dec(dec));
  // ==========================================
  // Write channel: address and data taken in either order.
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready = !w_have_q && !s_axi_bvalid;
  wire do_wr = aw_have_q && w_have_q && !s_axi_bvalid;
  wire busy = (state_q != S_IDLE);
  wire [7:0] wa = 8'(awaddr_q);
  wire wa_map = (wa <= REG_QUEUE) && (wa[1:0] == 2'h0);
  wire wa_ro = (wa == REG_STATUS) || (wa == REG_QUEUE);
  wire wr_ok = do_wr && wa_map && !(busy && !wa_ro);
  wire [31:0] wmask = aau_merge(32'h0, wdata_q, wstrb_q);
  // Latch the halves of a write until both are present.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (do_wr) aw_have_q <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (do_wr) w_have_q <= 1'b0;
    end
  end
  // Write response; unmapped writes, and busy writes outside status and queue, answer SLVERR.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
    end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
  end
  // ==========================================
  // Execution datapath for the single EXEC cycle.
  logic [15:0] acc_d;
  logic [31:0] long_d;
  logic link_d, exc, arith, cc16, cc32;
  logic [16:0] s17;
  logic [32:0] s33;
  always_comb begin
    acc_d = acc_q;
    long_d = long_q;
    link_d = link_q;
    exc = 1'b0;
    arith = 1'b1;
    cc16 = 1'b0;
    cc32 = 1'b0;
    s17 = 17'h0;
    s33 = 33'h0;
    case (dec.op)
      OP_INC1: begin
        s17 = {1'b0, acc_q} + 17'h1; // RL8
        acc_d = s17[15:0];
        exc = (acc_q == 16'h7fff);
        {link_d, cc16} = {s17[16], 1'b1};
      end
      OP_INC2: begin
        s17 = {1'b0, acc_q} + 17'h2; // RL9
        exc = (acc_q == 16'h7fff) || (acc_q == 16'h7ffe);
        acc_d = (acc_q == 16'h7fff) ? 16'h8000 : (acc_q == 16'h7ffe) ? 16'h8001 : s17[15:0];
        {link_d, cc16} = {s17[16], 1'b1};
      end
      OP_ACA: begin
        s17 = {1'b0, acc_q} + {16'h0, carry_q}; // RL12
        acc_d = s17[15:0];
        exc = (acc_q == 16'h7fff) && carry_q;
        {link_d, cc16} = {s17[16], 1'b1};
      end
      OP_ADD: begin
        s17 = {acc_q[15], acc_q} + {operand_q[15], operand_q[15:0]}; // RL13
        link_d = 1'(({1'b0, acc_q} + {1'b0, operand_q[15:0]}) >> 16);
        exc = (s17[16] != s17[15]);
        acc_d = !exc ? s17[15:0] : !s17[16] ? ADD_POS_OVF_LOAD : ADD_NEG_OVF_LOAD; // RL14
        cc16 = 1'b1;
      end
      OP_ADL: begin
        s33 = {long_q[31], long_q} + {operand_q[31], operand_q}; // RL15
        link_d = 1'(({1'b0, long_q} + {1'b0, operand_q}) >> 32);
        exc = (s33[32] != s33[31]);
        long_d = !exc ? s33[31:0] : !s33[32] ? ADL_POS_OVF_LOAD : ADL_NEG_OVF_LOAD;
        cc32 = 1'b1;
      end
      OP_ADD_LINK_TO_LONG: begin
        s33 = {1'b0, long_q} + {32'h0, link_q}; // RL16
        long_d = s33[31:0];
        exc = (long_q == 32'h7fffffff) && link_q;
        {link_d, cc32} = {s33[32], 1'b1};
      end
      default: arith = 1'b0;
    endcase
  end
  wire ex = (state_q == S_EXEC);
  wire step = (state_q == S_SHIFT);
  wire enq_go = ex && (dec.op == OP_ENQ) && !qfull_q;
  // Sequencer: a write to the instruction register starts one instruction.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= S_IDLE;
      steps_q <= 7'h0;
    end else begin
      case (state_q)
        S_IDLE: if (wr_ok && wa == REG_INSTR) state_q <= S_EXEC;
        S_EXEC: begin
          steps_q <= dec.steps; // RL7
          state_q <= (dec.op == OP_SHL || dec.op == OP_ROL) ? S_SHIFT : S_IDLE;
        end
        S_SHIFT: begin
          steps_q <= steps_q - 7'h1;
          if (steps_q == 7'h1) state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end
  // Instruction word and operand or address pointer.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      instr_q <= 16'h0;
      operand_q <= 32'h0;
    end else if (wr_ok) begin
      if (wa == REG_INSTR) instr_q <= 16'(aau_merge({16'h0, instr_q}, wdata_q, wstrb_q));
      if (wa == REG_OPERAND) operand_q <= aau_merge(operand_q, wdata_q, wstrb_q); // RL5
    end
  end
  // Accumulator: bus loads, arithmetic results and shift steps.
  always_ff @(posedge aclk) begin
    if (!aresetn) acc_q <= 16'h0;
    else if (ex && arith) acc_q <= acc_d;
    else if (step && dec.op == OP_SHL) acc_q <= {acc_q[14:0], 1'b0}; // RL18
    else if (step) acc_q <= {acc_q[14:0], acc_q[15]}; // RL19
    else if (wr_ok && wa == REG_ACC) acc_q <= 16'(aau_merge({16'h0, acc_q}, wdata_q, wstrb_q));
  end
  // Long register and field address registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      long_q <= 32'h0; // RL20
      far_q[0] <= 32'h0;
      far_q[1] <= 32'h0;
    end else if (ex) begin
      long_q <= long_d;
      if (dec.op == OP_ADD_LONG_TO_FIELD_ADDR) far_q[dec.far_sel] <= far_q[dec.far_sel] + long_q; // RL17
    end else if (wr_ok) begin
      if (wa == REG_LONG) long_q <= aau_merge(long_q, wdata_q, wstrb_q);
      if (wa == REG_FAR0) far_q[0] <= aau_merge(far_q[0], wdata_q, wstrb_q);
      if (wa == REG_FAR1) far_q[1] <= aau_merge(far_q[1], wdata_q, wstrb_q);
    end
  end
  // Keys: carry, link, condition codes and the fault enable.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {carry_q, link_q, fault_en_q} <= {KEYS_RESET[KEY_CARRY], KEYS_RESET[KEY_LINK], KEYS_RESET[KEY_FAULT_EN]};
      {cc_lt_q, cc_eq_q} <= {KEYS_RESET[KEY_CC_LT], KEYS_RESET[KEY_CC_EQ]};
    end else if (ex && arith) begin
      carry_q <= exc; // RL10
      link_q <= link_d;
      if (cc16) {cc_lt_q, cc_eq_q} <= aau_cc({{16{acc_d[15]}}, acc_d}); // RL21
      if (cc32) {cc_lt_q, cc_eq_q} <= aau_cc(long_d); // RL21
    end else if (ex && dec.op == OP_ENQ) begin
      {cc_lt_q, cc_eq_q} <= {1'b0, qfull_q}; // RL11
    end else if (step) begin
      carry_q <= acc_q[15]; // RL18 RL19
    end else if (wr_ok && wa == REG_KEYS) begin
      if (wstrb_q[1]) {carry_q, link_q, fault_en_q} <= {wdata_q[KEY_CARRY], wdata_q[KEY_LINK], wdata_q[KEY_FAULT_EN]};
      if (wstrb_q[0]) {cc_lt_q, cc_eq_q} <= {wdata_q[KEY_CC_LT], wdata_q[KEY_CC_EQ]};
    end
  end
  // Fault pulse, sticky fault flag (a new fault beats a clear) and status.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_fault <= 1'b0;
      fault_seen_q <= 1'b0;
      exc_q <= 1'b0;
      unsup_q <= 1'b0;
      qfull_q <= 1'b0;
    end else begin
      int_fault <= ex && exc && fault_en_q; // RL10
      if (ex && exc && fault_en_q) fault_seen_q <= 1'b1;
      else if (wr_ok && wa == REG_STATUS && wmask[STAT_FAULT]) fault_seen_q <= 1'b0;
      if (ex) exc_q <= exc;
      if (ex) unsup_q <= (dec.op == OP_NONE);
      if (wr_ok && wa == REG_QUEUE && wstrb_q[0]) qfull_q <= wdata_q[0];
    end
  end
  // Queue insertion port and the fetch fence that follows a store.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enq_valid <= 1'b0;
      enq_data <= 16'h0;
      enq_ap <= 32'h0;
      fence_q <= 3'h0;
    end else begin
      enq_valid <= enq_go; // RL11
      if (enq_go) {enq_data, enq_ap} <= {acc_q, operand_q};
      if (enq_go) fence_q <= FENCE_COUNT; // RL1
      else if (ex && dec.op == OP_MODE) fence_q <= 3'h0; // RL1
      else if (ex && fence_q != 3'h0) fence_q <= fence_q - 3'h1;
    end
  end
  assign fetch_stale = (fence_q != 3'h0);
  // ==========================================
  // Read channel with registered data.
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h0;
      case (8'(s_axi_araddr))
        REG_INSTR: s_axi_rdata <= {16'h0, instr_q};
        REG_OPERAND: s_axi_rdata <= operand_q;
        REG_ACC: s_axi_rdata <= {16'h0, acc_q};
        REG_LONG: s_axi_rdata <= long_q;
        REG_KEYS: begin
          s_axi_rdata[KEY_CARRY] <= carry_q;
          s_axi_rdata[KEY_LINK] <= link_q;
          s_axi_rdata[KEY_FAULT_EN] <= fault_en_q;
          s_axi_rdata[KEY_CC_LT] <= cc_lt_q;
          s_axi_rdata[KEY_CC_EQ] <= cc_eq_q;
        end
        REG_FAR0: s_axi_rdata <= far_q[0];
        REG_FAR1: s_axi_rdata <= far_q[1];
        REG_STATUS: begin
          s_axi_rdata[STAT_BUSY] <= busy;
          s_axi_rdata[STAT_FAULT] <= fault_seen_q;
          s_axi_rdata[STAT_EXC] <= exc_q;
          s_axi_rdata[STAT_STALE] <= fetch_stale;
          s_axi_rdata[STAT_UNSUP] <= unsup_q;
          s_axi_rdata[STAT_CLASS +: 3] <= dec.cls;
        end
        REG_QUEUE: s_axi_rdata <= {31'h0, qfull_q};
        default: s_axi_rresp <= 2'h2;
      endcase
    end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
  end

  // ==========================================
  // Checks on the decode and execution behaviour.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  io_not_memref_a: assert property (dec.cls == CLS_IO |-> dec.op == OP_NONE) // RL2
    else $error("Input/output opcode decoded as an operation.");
  opc15_index_a: assert property (dec.mr_opc == OPC_X_IN_OPC |-> !dec.index_req) // RL3
    else $error("Index requested for opcode octal 15.");
  long_ext_a: assert property (dec.cls == CLS_MR_LONG && dec.mr_opc == OPC_ADD
      && dec.long_ext == EXT_ADL |-> dec.op == OP_ADL) // RL4
    else $error("Long add not decoded from its extension.");
  inc_wrap_a: assert property (ex && dec.op == OP_INC1 && acc_q == 16'h7fff
      |=> acc_q == 16'h8000 && carry_q && s_axi_bresp == $past(s_axi_bresp)) // RL8
    else $error("Increment did not wrap with exception.");
  inc2_wrap_a: assert property (ex && dec.op == OP_INC2 && acc_q == 16'h7ffe |=> acc_q == 16'h8001) // RL9
    else $error("Add two from second largest is wrong.");
  fault_key_a: assert property (ex && exc |=> int_fault == $past(fault_en_q) ##1 !int_fault) // RL10
    else $error("Fault pulse does not follow the key.");
  carry_clr_a: assert property (ex && arith && !exc |=> !carry_q) // RL10
    else $error("Carry flag not cleared without exception.");
  enq_flags_a: assert property (ex && dec.op == OP_ENQ
      |=> cc_eq_q == $past(qfull_q) && $stable(carry_q) && $stable(link_q)) // RL11
    else $error("Enqueue flags wrong.");
  add_sat_a: assert property (ex && dec.op == OP_ADD && !s17[16] && s17[15]
      |=> acc_q == ADD_POS_OVF_LOAD && carry_q) // RL14
    else $error("Add overflow value wrong.");
  shift_one_a: assert property (ex && dec.op == OP_SHL && dec.steps == 7'h1
      |=> step ##1 state_q == S_IDLE) // RL7 RL18
    else $error("Single shift step count wrong.");
  rot_full_a: assert property (ex && dec.op == OP_ROL && dec.steps == 7'h10
      |=> ##16 acc_q == $past(acc_q, 17)) // RL19
    else $error("Sixteen-step rotate changed the accumulator.");
  fence_a: assert property (enq_go |=> fence_q == FENCE_COUNT) // RL1
    else $error("Fetch fence not armed by a store.");
  fence_step_a: assert property (ex && fetch_stale && !enq_go && dec.op != OP_MODE
      |=> fence_q == $past(fence_q) - 3'h1) // RL1
    else $error("Fetch fence did not count the instruction.");
  shift64_c: cover property (ex && dec.op == OP_SHL && dec.steps == SHIFT_ZERO_STEPS);
  fault_c: cover property (int_fault);
  enq_full_c: cover property (ex && dec.op == OP_ENQ && qfull_q);
  adl_ovf_c: cover property (ex && dec.op == OP_ADL && exc);
endmodule : aau_top

// File: rtl/aau_pkg.sv
/*
  Shared constants and types of the accumulator add and shift unit.
  Assumes a 16-bit instruction word with bit 1 as the msb ([15]).
*/
package aau_pkg;
  // ==========================================
  // Register map, byte addresses.
  localparam logic [7:0] REG_INSTR = 8'h00;
  localparam logic [7:0] REG_OPERAND = 8'h04;
  localparam logic [7:0] REG_ACC = 8'h08;
  localparam logic [7:0] REG_LONG = 8'h0c;
  localparam logic [7:0] REG_KEYS = 8'h10;
  localparam logic [7:0] REG_FAR0 = 8'h14;
  localparam logic [7:0] REG_FAR1 = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h1c;
  localparam logic [7:0] REG_QUEUE = 8'h20;
  // Keys fields and reset value.
  localparam int KEY_CARRY = 15;
  localparam int KEY_LINK = 13;
  localparam int KEY_FAULT_EN = 8;
  localparam int KEY_CC_LT = 7;
  localparam int KEY_CC_EQ = 6;
  localparam logic [15:0] KEYS_RESET = 16'h0000;
  // Status fields.
  localparam int STAT_BUSY = 0;
  localparam int STAT_FAULT = 1;
  localparam int STAT_EXC = 2;
  localparam int STAT_STALE = 3;
  localparam int STAT_UNSUP = 4;
  localparam int STAT_CLASS = 8;
  // Counts, opcode field codes and saturation values.
  localparam logic [2:0] FENCE_COUNT = 3'h5;
  localparam logic [6:0] SHIFT_ZERO_STEPS = 7'h40;
  localparam logic [3:0] OPC_IO = 4'hc;
  localparam logic [3:0] OPC_X_IN_OPC = 4'hd;
  localparam logic [3:0] OPC_ADD = 4'h6;
  localparam logic [4:0] LONG_MARK = 5'h18;
  localparam logic [1:0] EXT_ADD = 2'h0;
  localparam logic [1:0] EXT_ADL = 2'h3;
  localparam logic [15:0] ADD_POS_OVF_LOAD = 16'h7fff;
  localparam logic [15:0] ADD_NEG_OVF_LOAD = 16'h7fff;
  localparam logic [31:0] ADL_POS_OVF_LOAD = 32'h7fffffff;
  localparam logic [31:0] ADL_NEG_OVF_LOAD = 32'h7fffffff;
  // Full-word opcodes, the field-select mask and 10-bit shift prefixes.
  localparam logic [15:0] OPW_INC1 = 16'hc0c0;
  localparam logic [15:0] OPW_INC2 = 16'hc0c4;
  localparam logic [15:0] OPW_ENQ = 16'hc3ce;
  localparam logic [15:0] OPW_ACA = 16'hc28e;
  localparam logic [15:0] OPW_ADD_LINK_TO_LONG = 16'hc200;
  localparam logic [15:0] OPW_ADD_LONG_TO_FIELD_ADDR = 16'h02c1;
  localparam logic [15:0] OPW_FAR_SEL = 16'h0008;
  localparam logic [15:0] OPW_MODE = 16'h000b;
  localparam logic [9:0] OPS_SHL = 10'h10c;
  localparam logic [9:0] OPS_ROL = 10'h10e;

  typedef enum logic [2:0] {
    CLS_GEN_A = 3'h0, CLS_GEN_B = 3'h1, CLS_SHIFT = 3'h2, CLS_SKIP = 3'h3,
    CLS_MR_SHORT = 3'h4, CLS_MR_LONG = 3'h5, CLS_IO = 3'h6
  } aau_class_t;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_INC1 = 4'h1, OP_INC2 = 4'h2, OP_ENQ = 4'h3, OP_ACA = 4'h4, OP_ADD = 4'h5,
    OP_ADL = 4'h6, OP_ADD_LINK_TO_LONG = 4'h7, OP_ADD_LONG_TO_FIELD_ADDR = 4'h8, OP_SHL = 4'h9, OP_ROL = 4'ha, OP_MODE = 4'hb
  } aau_op_t;

  typedef enum logic [2:0] {S_IDLE = 3'b001, S_EXEC = 3'b010, S_SHIFT = 3'b100} aau_state_t;

  typedef struct packed {
    aau_class_t cls;
    aau_op_t op;
    logic [3:0] mr_opc;
    logic [1:0] long_ext;
    logic [9:0] ext;
    logic index_req;
    logic needs_ap;
    logic far_sel;
    logic [6:0] steps;
  } aau_dec_t;

  // Condition codes {lt, eq} of a signed result.
  function automatic logic [1:0] aau_cc(input logic [31:0] v);
    return {v[31], v == 32'h0};
  endfunction : aau_cc

  // Byte-lane merge of a bus write into a register.
  function automatic logic [31:0] aau_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) if (strb[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction : aau_merge
endpackage : aau_pkg

// File: rtl/aau_decode.sv
/*
  Instruction classifier of the accumulator add and shift unit.
  Purely combinational; the caller registers the instruction word.
*/
`timescale 1ns/1ps
module aau_decode (
  input wire logic [15:0] ins,
  output aau_pkg::aau_dec_t dec
);
  import aau_pkg::*;

  // ==========================================
  // Classification and operation decode.
  always_comb begin
    logic [5:0] n;
    n = ins[5:0];
    dec = '0;
    dec.mr_opc = ins[13:10]; // RL2
    dec.ext = ins[9:0];
    dec.long_ext = ins[3:2];
    dec.far_sel = ins[3];
    dec.steps = (n == 6'h0) ? SHIFT_ZERO_STEPS : {1'b0, 6'(-n)}; // RL7
    dec.op = OP_NONE;
    if (ins[13:10] == 4'h0) begin
      case (ins[15:14]) // RL6
        2'b11: dec.cls = CLS_GEN_A;
        2'b00: dec.cls = CLS_GEN_B;
        2'b01: dec.cls = CLS_SHIFT;
        default: dec.cls = CLS_SKIP;
      endcase
      if (ins == OPW_INC1) dec.op = OP_INC1;
      else if (ins == OPW_INC2) dec.op = OP_INC2;
      else if (ins == OPW_ACA) dec.op = OP_ACA;
      else if (ins == OPW_ADD_LINK_TO_LONG) dec.op = OP_ADD_LINK_TO_LONG;
      else if (ins == OPW_MODE) dec.op = OP_MODE;
      else if ((ins & ~OPW_FAR_SEL) == OPW_ADD_LONG_TO_FIELD_ADDR) dec.op = OP_ADD_LONG_TO_FIELD_ADDR; // RL17
      else if (ins[15:6] == OPS_SHL) dec.op = OP_SHL;
      else if (ins[15:6] == OPS_ROL) dec.op = OP_ROL;
      else if (ins == OPW_ENQ) begin
        dec.op = OP_ENQ;
        dec.needs_ap = 1'b1; // RL5
      end
    end else if (ins[13:10] == OPC_IO) begin
      dec.cls = CLS_IO; // RL2
    end else begin
      dec.cls = (ins[9:5] == LONG_MARK) ? CLS_MR_LONG : CLS_MR_SHORT;
      dec.index_req = ins[14] && (ins[13:10] != OPC_X_IN_OPC); // RL3
      if (ins[13:10] == OPC_ADD) begin
        if (ins[9:5] != LONG_MARK || ins[3:2] == EXT_ADD) dec.op = OP_ADD;
        else if (ins[3:2] == EXT_ADL) dec.op = OP_ADL; // RL4
      end
    end
  end
endmodule : aau_decode

// File: dv/aau_queue_model.sv
/*
  Queue sink standing for the memory side of enqueue-at-bottom requests.
  Assumes enqueue requests are one-cycle pulses on aclk.
*/
`timescale 1ns/1ps
module aau_queue_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic enq_valid,
  input wire logic [15:0] enq_data,
  input wire logic [31:0] enq_ap,
  output int count,
  output logic [15:0] last_q,
  output logic [31:0] last_ap
);
  // ==========================================
  // Each request pulse adds one entry at the bottom of the queue.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= 0;
      last_q <= 16'h0000;
      last_ap <= 32'h0000_0000;
    end else if (enq_valid) begin
      count <= count + 1;
      last_q <= enq_data;
      last_ap <= enq_ap;
    end
  end
endmodule : aau_queue_model

// File: dv/accumulator_add_shift_unit_bench.sv
/*
  Self-checking bench: loads operands over AXI4-Lite, runs one instruction, reads back.
  Assumes the register map and keys layout of the unit package.
*/
`timescale 1ns/1ps
module accumulator_add_shift_unit_bench;
  import aau_pkg::*;
  typedef struct packed {
    logic [15:0] ins; logic [31:0] opd; logic [15:0] acc; logic [31:0] lng;
    logic [15:0] keys; logic [7:0] rg; logic [31:0] res; logic [15:0] ek;
  } aau_row_t;
  logic aclk = 0, aresetn = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, rdat;
  logic awready, wready, bvalid, arready, rvalid, int_fault, enq_valid, fetch_stale;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, enq_ap, q_ap;
  logic [15:0] enq_data, q_last;
  int failures = 0, n_tests = 0, q_count, k, n_fault = 0;
  aau_row_t rows [15];
  aau_top aau_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .int_fault(int_fault),
    .enq_valid(enq_valid), .enq_data(enq_data), .enq_ap(enq_ap), .fetch_stale(fetch_stale));
  aau_queue_model aau_queue_model_inst (.aclk(aclk), .aresetn(aresetn), .enq_valid(enq_valid),
    .enq_data(enq_data), .enq_ap(enq_ap), .count(q_count), .last_q(q_last), .last_ap(q_ap));
  // ==========================================
  // Clock of 100 ns period.
  initial forever #50 aclk = ~aclk;
  // Counts fault pulses as they stand at each rising edge.
  always @(posedge aclk) if (int_fault === 1'b1) n_fault++;
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // Bus cycles hold each channel until its own ready is seen at an edge.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid) break;
    end
    if (i == 50) begin failures++; results(); end
    resp = bresp;
    bready <= 0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int i;
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 0;
      if (rvalid) break;
    end
    if (i == 50) begin failures++; results(); end
    rdat = rdata; resp = rresp;
    rready <= 0;
  endtask : rd
  // Loads the operands, starts the instruction, waits for idle and checks results.
  task automatic run(input aau_row_t r);
    int i;
    wr(REG_ACC, {16'h0, r.acc}); wr(REG_LONG, r.lng); wr(REG_KEYS, {16'h0, r.keys});
    wr(REG_OPERAND, r.opd); wr(REG_INSTR, {16'h0, r.ins});
    for (i = 0; i < 100; i++) begin
      rd(REG_STATUS);
      if (rdat[STAT_BUSY] === 1'b0) break;
    end
    if (i == 100) begin failures++; results(); end
    rd(r.rg); chk(rdat, r.res);
    rd(REG_KEYS); chk(rdat, {16'h0, r.ek});
    $display("test of instruction %h done", r.ins);
  endtask : run
  initial begin
    rows = '{
      '{16'hc0c0, 32'h0, 16'h0005, 32'h0, 16'h0000, REG_ACC, 32'h0006, 16'h0000},
      '{16'hc0c0, 32'h0, 16'h7fff, 32'h0, 16'h0000, REG_ACC, 32'h8000, 16'h8080},
      '{16'hc0c4, 32'h0, 16'h7ffe, 32'h0, 16'h0000, REG_ACC, 32'h8001, 16'h8080},
      '{16'hc0c4, 32'h0, 16'h7fff, 32'h0, 16'h0000, REG_ACC, 32'h8000, 16'h8080},
      '{16'hc28e, 32'h0, 16'h7fff, 32'h0, 16'h8000, REG_ACC, 32'h8000, 16'h8080},
      '{16'h1800, 32'h3, 16'h0004, 32'h0, 16'h0000, REG_ACC, 32'h0007, 16'h0000},
      '{16'h1800, 32'h1, 16'hffff, 32'h0, 16'h0000, REG_ACC, 32'h0000, 16'h2040},
      '{16'h1800, 32'h1, 16'h7fff, 32'h0, 16'h0000, REG_ACC, {16'h0, ADD_POS_OVF_LOAD}, 16'h8000},
      '{16'hc200, 32'h0, 16'h0000, 32'h7fffffff, 16'h2000, REG_LONG, 32'h80000000, 16'h8080},
      '{16'h433e, 32'h0, 16'hc001, 32'h0, 16'h00c0, REG_ACC, 32'h0004, 16'h80c0},
      '{16'h43bf, 32'h0, 16'h8001, 32'h0, 16'h0000, REG_ACC, 32'h0003, 16'h8000},
      '{16'h4380, 32'h0, 16'h1235, 32'h0, 16'h0000, REG_ACC, 32'h1235, 16'h8000},
      '{16'h1b0c, 32'h1, 16'h0000, 32'h7fffffff, 16'h0000, REG_LONG, ADL_POS_OVF_LOAD, 16'h8000},
      '{16'h433f, 32'h0, 16'h8001, 32'h0, 16'h0000, REG_ACC, 32'h0002, 16'h8000},
      '{16'h43b0, 32'h0, 16'h1235, 32'h0, 16'h0000, REG_ACC, 32'h1235, 16'h8000}};
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    rd(REG_KEYS); chk(rdat, {16'h0, KEYS_RESET});
    for (k = 0; k < 15; k++) run(rows[k]);
    // Fault enabled: exception must leave the sticky fault flag set.
    run('{16'hc0c0, 32'h0, 16'h7fff, 32'h0, 16'h0100, REG_ACC, 32'h8000, 16'h8180});
    rd(REG_STATUS); chk(rdat[STAT_FAULT], 1'b1);
    chk(n_fault, 1);
    // Field address add into the first field address register.
    wr(REG_FAR0, 32'h100);
    chk(resp, 2'h0);
    run('{OPW_ADD_LONG_TO_FIELD_ADDR, 32'h0, 16'h0, 32'h10, 16'h0040, REG_FAR0, 32'h110, 16'h0040});
    // Unmapped read and write are refused.
    rd(8'h24); chk(resp, 2'h2);
    wr(8'h24, 32'h0); chk(resp, 2'h2);
    // Enqueue to a queue with room, then to a full one.
    wr(REG_QUEUE, 32'h0);
    run('{OPW_ENQ, 32'h1234, 16'h55aa, 32'h0, 16'h8000, REG_ACC, 32'h55aa, 16'h8000});
    chk(q_count, 1); chk(q_last, 16'h55aa); chk(fetch_stale, 1'b1);
    chk(q_ap, 32'h1234);
    wr(REG_QUEUE, 32'h1);
    run('{OPW_ENQ, 32'h1234, 16'h1111, 32'h0, 16'h2000, REG_ACC, 32'h1111, 16'h2040});
    chk(q_count, 1);
    run('{OPW_MODE, 32'h0, 16'h0, 32'h0, 16'h0, REG_ACC, 32'h0, 16'h0});
    chk(fetch_stale, 1'b0);
    results();
  end
endmodule : accumulator_add_shift_unit_bench
